// [rtl/cbpm_pkg.sv]
// constants shared by the cell balance pwm monitor and its channels
//
// Contract
// RULE1 - watchdog running: outputs follow enable bits
// RULE2 - watchdog expired: modulate until timeout or wake
// RULE3 - disabled channel stays off during modulation
// RULE4 - modulation period is thirty seconds
// RULE5 - on time is two seconds per code
// RULE6 - channels switch 62.5 ms apart
// RULE7 - duty codes reset to ones, also on sleep
// RULE8 - host sets monitor enable for periodic checks
// RULE9 - monitor converts all cells every thirty seconds
// RULE10 - compare cells, set over/under voltage flags
// RULE11 - undervolted cell loses its discharge enable
// RULE12 - redundancy failure clears every discharge enable
// RULE13 - host sets undervoltage threshold to end level
// RULE14 - timeout before watchdog: disable, reset duty codes
// RULE15 - channel n offset by n stagger steps
// RULE16 - all timing counts one shared slow tick
package cbpm_pkg;
  localparam int NCH = 15;
  localparam int CELL_W = 16;
  // timing figures in their own units
  localparam int CLK_PERIOD_PS = 4000;
  localparam longint STAGGER_PS = 64'd62_500_000_000;
  localparam int PERIOD_S = 30;
  localparam int ON_STEP_S = 2;
  localparam int TICK_CYC = int'(STAGGER_PS / CLK_PERIOD_PS);
  localparam int PERIOD_TICKS = int'(64'(PERIOD_S) * 64'd1_000_000_000_000 / STAGGER_PS);
  localparam int ON_STEP_TICKS = int'(64'(ON_STEP_S) * 64'd1_000_000_000_000 / STAGGER_PS);
  localparam int TCNT_W = 9;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_DISCH = 8'h04;
  localparam logic [7:0] OFS_DUTY_LO = 8'h08;
  localparam logic [7:0] OFS_DUTY_HI = 8'h0C;
  localparam logic [7:0] OFS_UV_THR = 8'h10;
  localparam logic [7:0] OFS_OV_THR = 8'h14;
  localparam logic [7:0] OFS_OV_FLAGS = 8'h18;
  localparam logic [7:0] OFS_UV_FLAGS = 8'h1C;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h20;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h24;
  localparam logic [7:0] OFS_STATE = 8'h28;
  // field positions
  localparam int CTRL_MON_EN_BIT = 0;
  localparam int IRQ_UV_BIT = 0;
  localparam int IRQ_OV_BIT = 1;
  localparam int IRQ_RED_BIT = 2;
  localparam int IRQ_DONE_BIT = 3;
  localparam int IRQ_W = 4;
  localparam int STATE_TICK_LSB = 16;
  // values after reset
  localparam logic [NCH*4-1:0] DUTY_RST = {NCH{4'h_f}};
  localparam logic [NCH-1:0] DISCH_RST = 15'h_0000;
  localparam logic [CELL_W-1:0] UV_THR_RST = 16'h_0000;
  localparam logic [CELL_W-1:0] OV_THR_RST = 16'h_ffff;
  typedef enum logic {MON_IDLE, MON_WAIT} cbpm_mon_e;
endpackage

// [rtl/cbpm_tb_if.sv]
// shared slow timebase carried from the top to every channel
`timescale 1ns/100ps
interface cbpm_tb_if;
  import cbpm_pkg::*;
  logic [TCNT_W-1:0] tick_cnt;
  logic modulate;
  modport src (output tick_cnt, output modulate);
  modport chan (input tick_cnt, input modulate);
endinterface

// [rtl/cbpm_chan.sv]
// one balancing channel: direct drive or staggered pwm
`timescale 1ns/100ps
module cbpm_chan
  import cbpm_pkg::*;
#(
  parameter int CH = 0
)
(
  input wire logic mclk,
  input wire logic sys_rst,
  cbpm_tb_if.chan tb,
  input wire logic enable,
  input wire logic [3:0] duty,
  output logic out
);
  localparam logic [TCNT_W:0] OFFSET = (TCNT_W+1)'(CH);
  localparam logic [TCNT_W:0] PERIOD = (TCNT_W+1)'(PERIOD_TICKS);
  logic [TCNT_W:0] phase;
  logic [TCNT_W:0] on_ticks;
  logic out_d;
  logic out_q;

  // position inside this channel's own shifted period
  always_comb
  begin
    if ({1'b0, tb.tick_cnt} >= OFFSET) // RULE15
      phase = {1'b0, tb.tick_cnt} - OFFSET;
    else
      phase = {1'b0, tb.tick_cnt} + PERIOD - OFFSET; // RULE4
    on_ticks = (TCNT_W+1)'(duty) * (TCNT_W+1)'(ON_STEP_TICKS); // RULE5
    // code all ones gives on_ticks equal to the period, so always on
    if (!tb.modulate)
      out_d = enable; // RULE1
    else
      out_d = enable && (phase < on_ticks); // RULE3 RULE6
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      out_q <= 1'b0;
    else
      out_q <= out_d;
  end

  assign out = out_q;
endmodule

// [rtl/cbpm_top.sv]
// cell balance pwm and discharge timer monitor, register port and irq
`timescale 1ns/100ps
module cbpm_top
  import cbpm_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
)
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [7:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [31:0] bus_rdata,
  input wire logic wdog_expired,
  input wire logic wake_event,
  input wire logic sleep_enter,
  input wire logic dtimeout,
  output logic conv_req,
  input wire logic adc_done,
  input wire logic [NCH*CELL_W-1:0] adc_cells,
  input wire logic adc_redund_fail,
  output logic [NCH-1:0] balance_out,
  output logic irq
);
  // timebase and modulation flag shared with every channel
  cbpm_tb_if tb ();

  // ---------------------------------------------------------------
  // slow timebase
  // ---------------------------------------------------------------
  logic [31:0] div_q, div_d;
  logic [TCNT_W-1:0] tcnt_q, tcnt_d;
  logic mod_q, mod_d;
  logic tick;
  logic period_start;
  logic mod_start;

  // one tick per stagger step drives every period and on time
  always_comb
  begin
    tick = mod_q && (div_q == 32'(TICK_CYCLES - 1)); // RULE16
    mod_d = mod_q;
    if (!wdog_expired || wake_event || dtimeout)
      mod_d = 1'b0; // RULE2
    else if (wdog_expired)
      mod_d = 1'b1; // RULE2
    mod_start = mod_d && !mod_q;
    div_d = div_q;
    tcnt_d = tcnt_q;
    if (!mod_q)
    begin
      div_d = 32'h_0000_0000;
      tcnt_d = '0;
    end
    else if (tick)
    begin
      div_d = 32'h_0000_0000;
      if (tcnt_q == TCNT_W'(PERIOD_TICKS - 1))
        tcnt_d = '0; // RULE4
      else
        tcnt_d = tcnt_q + 1'b1;
    end
    else
      div_d = div_q + 32'h_0000_0001;
    period_start = mod_start || (tick && tcnt_q == TCNT_W'(PERIOD_TICKS - 1));
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      div_q <= 32'h_0000_0000;
      tcnt_q <= '0;
      mod_q <= 1'b0;
    end
    else
    begin
      div_q <= div_d;
      tcnt_q <= tcnt_d;
      mod_q <= mod_d;
    end
  end

  // channels see the registered count, so all of them agree on one tick
  assign tb.tick_cnt = tcnt_q;
  assign tb.modulate = mod_q;

  // ---------------------------------------------------------------
  // monitor sequencer
  // ---------------------------------------------------------------
  cbpm_mon_e mon_q, mon_d;
  logic req_q, req_d;
  logic mon_en_q;
  logic [NCH-1:0] uv_hit, ov_hit;
  logic result_ok;
  logic [CELL_W-1:0] uv_thr_q, ov_thr_q;

  // threshold compare of one returned cell
  function automatic logic [CELL_W-1:0] cell_of(input logic [NCH*CELL_W-1:0] v,
                                                  input int n);
    cell_of = v[n*CELL_W +: CELL_W];
  endfunction

  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++)
    begin : g_cmp
      assign uv_hit[gi] = cell_of(adc_cells, gi) < uv_thr_q; // RULE10
      assign ov_hit[gi] = cell_of(adc_cells, gi) > ov_thr_q; // RULE10
    end
  endgenerate

  // a conversion starts at each period start while enabled and no result is pending
  always_comb
  begin
    mon_d = mon_q;
    req_d = 1'b0;
    result_ok = 1'b0;
    unique case (mon_q)
      MON_IDLE:
        if (mon_en_q && period_start) // RULE8 RULE9
        begin
          req_d = 1'b1; // RULE9
          mon_d = MON_WAIT;
        end
      MON_WAIT:
        if (!mod_d)
          mon_d = MON_IDLE; // result of a stopped run is discarded
        else if (adc_done)
        begin
          result_ok = 1'b1;
          mon_d = MON_IDLE;
        end
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      mon_q <= MON_IDLE;
      req_q <= 1'b0;
    end
    else
    begin
      mon_q <= mon_d;
      req_q <= req_d;
    end
  end

  assign conv_req = req_q;

  // ---------------------------------------------------------------
  // register file and interrupt
  // ---------------------------------------------------------------
  logic mon_en_d;
  logic [NCH-1:0] dis_q, dis_d;
  logic [NCH*4-1:0] duty_q, duty_d;
  logic [CELL_W-1:0] uv_thr_d, ov_thr_d;
  logic [NCH-1:0] ovf_q, ovf_d, uvf_q, uvf_d;
  logic [IRQ_W-1:0] ist_q, ist_d, imsk_q, imsk_d, iset;
  logic [31:0] rd_q, rd_d;
  logic wr_hit;

  // software writes first, hardware clears and sets override them
  always_comb
  begin
    mon_en_d = mon_en_q;
    dis_d = dis_q;
    duty_d = duty_q;
    uv_thr_d = uv_thr_q;
    ov_thr_d = ov_thr_q;
    ovf_d = ovf_q;
    uvf_d = uvf_q;
    ist_d = ist_q;
    imsk_d = imsk_q;
    wr_hit = bus_wr;
    if (wr_hit)
    begin
      unique case (bus_addr)
        OFS_CTRL: mon_en_d = bus_wdata[CTRL_MON_EN_BIT];
        OFS_DISCH: dis_d = bus_wdata[NCH-1:0];
        OFS_DUTY_LO: duty_d[31:0] = bus_wdata;
        OFS_DUTY_HI: duty_d[NCH*4-1:32] = bus_wdata[NCH*4-33:0];
        OFS_UV_THR: uv_thr_d = bus_wdata[CELL_W-1:0]; // RULE13
        OFS_OV_THR: ov_thr_d = bus_wdata[CELL_W-1:0];
        OFS_OV_FLAGS: ovf_d = ovf_q & ~bus_wdata[NCH-1:0];
        OFS_UV_FLAGS: uvf_d = uvf_q & ~bus_wdata[NCH-1:0];
        OFS_IRQ_STAT: ist_d = ist_q & ~bus_wdata[IRQ_W-1:0];
        OFS_IRQ_MASK: imsk_d = bus_wdata[IRQ_W-1:0];
        default: ;
      endcase
    end
    // events of this cycle, merged after the software clear
    iset = '0;
    if (result_ok)
    begin
      ovf_d = ovf_d | ov_hit; // RULE10
      uvf_d = uvf_d | uv_hit; // RULE10
      dis_d = dis_d & ~uv_hit; // RULE11
      iset[IRQ_DONE_BIT] = 1'b1;
      iset[IRQ_UV_BIT] = |uv_hit;
      iset[IRQ_OV_BIT] = |ov_hit;
      if (adc_redund_fail)
      begin
        dis_d = '0; // RULE12
        iset[IRQ_RED_BIT] = 1'b1;
      end
    end
    // a timeout with the watchdog still running stops all discharge
    if (dtimeout && !wdog_expired)
    begin
      dis_d = '0; // RULE14
      duty_d = DUTY_RST; // RULE14
    end
    // sleep only restores duty codes; enables are left to software
    if (sleep_enter)
      duty_d = DUTY_RST; // RULE7
    ist_d = ist_d | iset; // set wins over a same-cycle clear
  end

  // read data stand in the cycle after the strobe only
  always_comb
  begin
    rd_d = 32'h_0000_0000;
    if (bus_rd)
    begin
      unique case (bus_addr)
        OFS_CTRL: rd_d[CTRL_MON_EN_BIT] = mon_en_q;
        OFS_DISCH: rd_d[NCH-1:0] = dis_q;
        OFS_DUTY_LO: rd_d = duty_q[31:0];
        OFS_DUTY_HI: rd_d[NCH*4-33:0] = duty_q[NCH*4-1:32];
        OFS_UV_THR: rd_d[CELL_W-1:0] = uv_thr_q;
        OFS_OV_THR: rd_d[CELL_W-1:0] = ov_thr_q;
        OFS_OV_FLAGS: rd_d[NCH-1:0] = ovf_q;
        OFS_UV_FLAGS: rd_d[NCH-1:0] = uvf_q;
        OFS_IRQ_STAT: rd_d[IRQ_W-1:0] = ist_q;
        OFS_IRQ_MASK: rd_d[IRQ_W-1:0] = imsk_q;
        OFS_STATE:
        begin
          rd_d[0] = mod_q;
          rd_d[1] = (mon_q == MON_WAIT);
          rd_d[STATE_TICK_LSB +: TCNT_W] = tcnt_q;
        end
        default: rd_d = 32'h_0000_0000; // unmapped reads as zero
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      mon_en_q <= 1'b0;
      dis_q <= DISCH_RST;
      duty_q <= DUTY_RST; // RULE7
      uv_thr_q <= UV_THR_RST;
      ov_thr_q <= OV_THR_RST;
      ovf_q <= '0;
      uvf_q <= '0;
      ist_q <= '0;
      imsk_q <= '0;
      rd_q <= 32'h_0000_0000;
    end
    else
    begin
      mon_en_q <= mon_en_d;
      dis_q <= dis_d;
      duty_q <= duty_d;
      uv_thr_q <= uv_thr_d;
      ov_thr_q <= ov_thr_d;
      ovf_q <= ovf_d;
      uvf_q <= uvf_d;
      ist_q <= ist_d;
      imsk_q <= imsk_d;
      rd_q <= rd_d;
    end
  end

  assign bus_rdata = rd_q;
  // level interrupt, no latching beyond the sticky status bits
  assign irq = |(ist_q & imsk_q);

  // ---------------------------------------------------------------
  // balancing channels
  // ---------------------------------------------------------------
  generate
    for (gi = 0; gi < NCH; gi++)
    begin : g_ch
      cbpm_chan #(.CH(gi)) u_ch (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .tb(tb.chan),
        .enable(dis_q[gi]),
        .duty(duty_q[gi*4 +: 4]),
        .out(balance_out[gi])
      );
    end
  endgenerate
endmodule

// [testbench/cbpm_sva.sv]
// port checker for the cell balance pwm monitor
`timescale 1ns/100ps
module cbpm_sva
  import cbpm_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
)
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [31:0] bus_rdata,
  input wire logic wdog_expired,
  input wire logic wake_event,
  input wire logic dtimeout,
  input wire logic conv_req,
  input wire logic adc_done,
  input wire logic adc_redund_fail,
  input wire logic [NCH-1:0] balance_out,
  input wire logic irq
);
  // ----
  // helpers
  // ----
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  localparam int PER = PERIOD_TICKS * TICK_CYCLES;
  int gap_q;
  logic vld_q;
  // gap is only trusted while modulation runs unbroken
  always_ff @(posedge mclk)
  begin
    gap_q <= conv_req ? 1 : gap_q + 1;
    vld_q <= !sys_rst && wdog_expired && !wake_event && !dtimeout && (conv_req || vld_q);
  end
  // ----
  // properties
  // ----
  AST_RD_IDLE:
    assert property (!bus_rd |=> bus_rdata == 32'h_0000_0000) else $error("rdata without read");
  AST_CONV_PULSE:
    assert property (conv_req |=> !conv_req) else $error("conversion request too long");
  AST_CONV_GATE:
    assert property (!wdog_expired [*2] |=> !conv_req) else $error("conversion while running");
  AST_CONV_PERIOD:
    assert property (conv_req && vld_q |-> gap_q >= PER - 1 && gap_q <= PER + 1)
      else $error("conversion spacing wrong");
  AST_REDUND:
    assert property (adc_done && adc_redund_fail |=> ##1 balance_out == 15'h_0000)
      else $error("redundancy failure kept discharge");
  AST_TIMEOUT:
    assert property (dtimeout && !wdog_expired |=> ##1 balance_out == 15'h_0000)
      else $error("timeout kept discharge");
  AST_DIRECT:
    assert property ((!wdog_expired && !bus_wr && !dtimeout && !adc_done) [*4]
      |-> $stable(balance_out)) else $error("direct output moved");
  AST_IRQ_CAUSE:
    assert property ($rose(irq) |-> $past(adc_done) || $past(bus_wr)) else $error("irq no cause");
  cover property (conv_req && vld_q);
  cover property (adc_done && adc_redund_fail);
  cover property (dtimeout && !wdog_expired);
endmodule
bind cbpm_top cbpm_sva #(.TICK_CYCLES(TICK_CYCLES)) cbpm_sva_inst (.mclk(mclk),
  .sys_rst(sys_rst), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
  .wdog_expired(wdog_expired), .wake_event(wake_event), .dtimeout(dtimeout),
  .conv_req(conv_req), .adc_done(adc_done), .adc_redund_fail(adc_redund_fail),
  .balance_out(balance_out), .irq(irq));

// [testbench/cbpm_cells.sv]
// cell converter model answering conversion requests
`timescale 1ns/100ps
module cbpm_cells
  import cbpm_pkg::*;
(
  input wire logic mclk,
  input wire logic conv_req,
  input wire logic [NCH*CELL_W-1:0] volts,
  input wire logic bad,
  input wire logic slow,
  output logic adc_done,
  output logic [NCH*CELL_W-1:0] adc_cells,
  output logic adc_redund_fail
);
  int wait_q = -1;
  initial
  begin
    adc_done = 1'b0;
    adc_cells = '1;
    adc_redund_fail = 1'b0;
  end
  // one result per request; between results the data toggle so stale values never match
  always @(posedge mclk)
  begin
    adc_done <= (wait_q == 0);
    adc_cells <= (wait_q == 0) ? volts : ~adc_cells;
    adc_redund_fail <= (wait_q == 0) ? bad : ~adc_redund_fail;
    // an unknown request before reset must not poison the countdown forever
    wait_q <= (conv_req === 1'b1) ? (slow ? 40 : 1) : (wait_q >= 0 ? wait_q - 1 : -1);
  end
endmodule

// [testbench/cell_balance_pwm_monitor_test.sv]
// self-checking bench for the cell balance pwm monitor
`timescale 1ns/100ps
module cell_balance_pwm_monitor_test;
  import cbpm_pkg::*;
  localparam int TK = 4;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] bus_addr = 8'h_00;
  logic [31:0] bus_wdata = 32'h_0000_0000;
  logic bus_wr = 1'b0, bus_rd = 1'b0, wdog_expired = 1'b0, wake_event = 1'b0;
  logic sleep_enter = 1'b0, dtimeout = 1'b0, bad = 1'b0, slow = 1'b0;
  logic [31:0] bus_rdata;
  logic conv_req, adc_done, adc_redund_fail, irq;
  logic [NCH*CELL_W-1:0] adc_cells, volts = '0;
  logic [NCH-1:0] balance_out;
  logic [7:0] lfsr_q = 8'h_36;
  logic [63:0] dq = '0;
  int en, cyc = 0, start, err_total = 0, tests_run = 0;
  int code [NCH];
  // ----
  // clock and parts
  // ----
  always #2 mclk = ~mclk;
  always @(posedge mclk) cyc <= cyc + 1;
  cbpm_top #(.TICK_CYCLES(TK)) cbpm_top_inst (.mclk(mclk), .sys_rst(sys_rst),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_rdata(bus_rdata), .wdog_expired(wdog_expired), .wake_event(wake_event),
    .sleep_enter(sleep_enter), .dtimeout(dtimeout), .conv_req(conv_req),
    .adc_done(adc_done), .adc_cells(adc_cells), .adc_redund_fail(adc_redund_fail),
    .balance_out(balance_out), .irq(irq));
  cbpm_cells cbpm_cells_inst (.mclk(mclk), .conv_req(conv_req), .volts(volts), .bad(bad),
    .slow(slow), .adc_done(adc_done), .adc_cells(adc_cells), .adc_redund_fail(adc_redund_fail));
  // ----
  // tasks and model
  // ----
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge mclk);
    bus_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge mclk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge mclk);
    bus_rd <= 1'b0;
    #1 chk($sformatf("reg %h", a), exp, bus_rdata);
  endtask
  function automatic logic [7:0] lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction
  // channel n lags n ticks; the period and on step come from the shared tick
  function automatic logic [31:0] exp_out(input int k);
    logic [31:0] r = '0;
    for (int n = 0; n < NCH; n++)
      r[n] = en[n] && ((k - n + PERIOD_TICKS) % PERIOD_TICKS) < code[n] * ON_STEP_TICKS;
    return r;
  endfunction
  // sample mid-tick so the one-cycle output lag never matters
  task automatic at_tick(input int k);
    while (cyc < start + 3 + k * TK)
    begin
      @(posedge mclk);
      #1;
    end
    chk($sformatf("tick %0d", k), exp_out(k), 32'(balance_out));
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // hang guard, far beyond two periods
  initial
  begin
    #100000;
    err_total++;
    print_verdict;
  end
  // ----
  // main sequence
  // ----
  initial
  begin
    for (int n = 0; n < NCH; n++)
    begin
      code[n] = (n * 7) % 16;
      dq[n*4 +: 4] = code[n][3:0];
      volts[n*CELL_W +: CELL_W] = 16'h_8000;
    end
    volts[5*CELL_W +: CELL_W] = 16'h_3fff;
    volts[6*CELL_W +: CELL_W] = 16'h_c001;
    volts[7*CELL_W +: CELL_W] = 16'h_4000;
    volts[8*CELL_W +: CELL_W] = 16'h_c000;
    repeat (6) @(posedge mclk);
    sys_rst <= 1'b0;
    rd(OFS_DUTY_LO, 32'h_ffff_ffff);
    rd(OFS_DUTY_HI, 32'h_0fff_ffff);
    rd(OFS_OV_THR, 32'h_0000_ffff);
    rd(8'h_3c, 32'h_0000_0000);
    lfsr_q = lfsr(lfsr_q);
    en = ({lfsr_q, lfsr_q} | 32'h_0060) & 32'h_7ff7;
    wr(OFS_DISCH, en);
    repeat (2) @(posedge mclk);
    #1 chk("direct", en, 32'(balance_out));
    wr(OFS_DUTY_LO, dq[31:0]);
    wr(OFS_DUTY_HI, dq[63:32]);
    wr(OFS_UV_THR, 32'h_0000_4000);
    wr(OFS_OV_THR, 32'h_0000_c000);
    wr(OFS_IRQ_MASK, 32'h_0000_0001);
    wr(OFS_CTRL, 32'h_0000_0001);
    @(posedge mclk) wdog_expired <= 1'b1;
    @(posedge mclk) start = cyc;
    en = en & ~32'h_0020;
    for (int i = 0; i < 7; i++) at_tick(i * i * 6 + 2);
    rd(OFS_OV_FLAGS, 32'h_0000_0040);
    rd(OFS_UV_FLAGS, 32'h_0000_0020);
    wr(OFS_OV_FLAGS, 32'h_0000_0040);
    rd(OFS_OV_FLAGS, 32'h_0000_0000);
    rd(OFS_DISCH, en);
    chk("irq", 32'h_1, 32'(irq));
    rd(OFS_IRQ_STAT, 32'h_0000_000b);
    wr(OFS_IRQ_STAT, 32'h_0000_0001);
    #1 chk("irq", 32'h_0, 32'(irq));
    bad = 1'b1;
    slow = 1'b1;
    at_tick(484);
    en = 0;
    at_tick(495);
    rd(OFS_DISCH, 32'h_0000_0000);
    en = 32'h_2a55;
    wr(OFS_DISCH, en);
    @(posedge mclk)
    begin
      wdog_expired <= 1'b0;
      wake_event <= 1'b1;
    end
    @(posedge mclk) wake_event <= 1'b0;
    repeat (2) @(posedge mclk);
    #1 chk("wake", en, 32'(balance_out));
    @(posedge mclk) dtimeout <= 1'b1;
    @(posedge mclk) dtimeout <= 1'b0;
    repeat (2) @(posedge mclk);
    #1 chk("timeout", 32'h_0, 32'(balance_out));
    rd(OFS_DUTY_LO, 32'h_ffff_ffff);
    wr(OFS_DUTY_HI, 32'h_0000_0000);
    rd(OFS_DUTY_HI, 32'h_0000_0000);
    @(posedge mclk) sleep_enter <= 1'b1;
    @(posedge mclk) sleep_enter <= 1'b0;
    rd(OFS_DUTY_HI, 32'h_0fff_ffff);
    print_verdict;
  end
endmodule
